// ==== logic/hpbp_consts.svh ====
// Constants for the host processor bus port: widths, strobe timing.
// Assumes inclusion by both ends of the port and the type package.
`ifndef HPBP_CONSTS_SVH
`define HPBP_CONSTS_SVH

`define HPBP_DATA_W 16
`define HPBP_ADDR_W 18
// Clock period and device answer latency
`define HPBP_CLK_PERIOD_NS 25
`define HPBP_ACCESS_NS 50
`define HPBP_ACCESS_CYC ((`HPBP_ACCESS_NS + `HPBP_CLK_PERIOD_NS - 1) / `HPBP_CLK_PERIOD_NS)
// Bus mode codes
`define HPBP_MODE_STROBE 1'b0
`define HPBP_MODE_TSTART 1'b1

`endif

// ==== logic/hpbp_pkg.sv ====
// Types shared by both ends of the host processor bus port.
// Assumes the constants header is on the include path.
`include "hpbp_consts.svh"

package hpbp_pkg;
    typedef logic [`HPBP_DATA_W-1:0] hpbp_data_t;
    typedef logic [`HPBP_ADDR_W-1:0] hpbp_addr_t;
    typedef enum logic {hpbp_mode_strobe, hpbp_mode_tstart} hpbp_mode_t;
endpackage : hpbp_pkg

// ==== logic/hpbp_if.sv ====
// Interface joining host and device ends of the parallel port.
// Assumes a testbench resolves the shared wires from the enables.
`timescale 1ns/10ps

interface hpbp_if;
    import hpbp_pkg::*;
    // Data bus, three signals per end (enable low = driving)
    hpbp_data_t host_data_bus_h_o;
    logic host_data_bus_h_oe_n;
    hpbp_data_t host_data_bus_d_o;
    logic host_data_bus_d_oe_n;
    hpbp_data_t host_data_bus_i;
    // Address and control from host
    hpbp_addr_t host_address_bus;
    logic host_select_n;
    logic host_write_strobe;
    logic host_read_strobe;
    // Ready / acknowledge, three-state from device
    logic host_ready_out_o;
    logic host_ready_out_oe_n;
    logic host_ready_out_i;
    // Interrupts
    logic irq_main_out;
    logic irq_timer_out;

    modport device (
        input host_data_bus_i, host_address_bus, host_select_n, host_write_strobe, host_read_strobe,
        output host_data_bus_d_o, host_data_bus_d_oe_n, host_ready_out_o, host_ready_out_oe_n,
        output irq_main_out, irq_timer_out
    );
    modport host (
        input host_data_bus_i, host_ready_out_i, irq_main_out, irq_timer_out,
        output host_data_bus_h_o, host_data_bus_h_oe_n, host_address_bus, host_select_n,
        output host_write_strobe, host_read_strobe
    );
endinterface : hpbp_if

// ==== logic/hpbp_device.sv ====
// Device end of the host processor bus port.
// Assumes host pins come from another domain; core clock 40 MHz.
// Every host pin passes two flops, so answers lag the pins by clocks.
`timescale 1ns/10ps
`include "hpbp_consts.svh"

// Notes on behaviour
// - 16-bit bidirectional data, device drives on reads
// - Host gives 18-bit word address
// - Select gates access; otherwise ignored
// - Strobe mode: write strobe marks writes
// - Strobe mode: read strobe marks reads
// - Start mode: direction line shares write pin
// - Start mode: start strobe shares read pin
// - Ready after write capture or read data
// - Main interrupt on any special event
// - Timer interrupt from second timer set only
module hpbp_device
    import hpbp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Bus mode strap (0 strobe, 1 transfer start)
    input wire hpbp_mode_t bus_mode,
    // Host side
    hpbp_if.device bus,
    // Core side register access
    output hpbp_addr_t core_addr,
    output hpbp_data_t core_wdata,
    output logic core_wr,
    output logic core_rd,
    input wire hpbp_data_t core_rdata,
    // Events
    input wire logic main_event,
    input wire logic timer2_expired
);
    typedef enum logic [1:0] {hpbp_idle, hpbp_wait, hpbp_done} hpbp_state_t;

    // -----------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------
    logic [2:0] ctl_s1_q;
    logic [2:0] ctl_s2_q;
    // Two flops on select, write pin, read pin
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_s1_q <= 3'h7;
            ctl_s2_q <= 3'h7;
        end else begin
            ctl_s1_q <= {bus.host_select_n, bus.host_write_strobe, bus.host_read_strobe};
            ctl_s2_q <= ctl_s1_q;
        end
    end
    // Address and data pins on the same two-flop path as the controls;
    // the host sets them no later than select, so they are settled
    // when the synchronised select opens an access
    hpbp_addr_t addr_s1_q;
    hpbp_addr_t addr_s2_q;
    hpbp_data_t data_s1_q;
    hpbp_data_t data_s2_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_s1_q <= '0;
            addr_s2_q <= '0;
            data_s1_q <= '0;
            data_s2_q <= '0;
        end else begin
            addr_s1_q <= bus.host_address_bus;
            addr_s2_q <= addr_s1_q;
            data_s1_q <= bus.host_data_bus_i;
            data_s2_q <= data_s1_q;
        end
    end
    logic sel;
    logic wr_pin;
    logic rd_pin;
    logic want_wr;
    logic want_rd;
    assign sel = !ctl_s2_q[2];
    assign wr_pin = ctl_s2_q[1];
    assign rd_pin = ctl_s2_q[0];
    // Decode per mode; strobes active high in strobe mode
    always_comb begin
        if (bus_mode == hpbp_mode_strobe) begin
            want_wr = sel && wr_pin;
            want_rd = sel && rd_pin && !wr_pin;
        end else begin
            want_wr = sel && rd_pin && !wr_pin;
            want_rd = sel && rd_pin && wr_pin;
        end
    end

    // -----------------------------------------------
    // Access sequencer
    // -----------------------------------------------
    // Wait count covers the access time; done holds until strobe drops
    hpbp_state_t state_q;
    logic is_wr_q;
    logic [1:0] cnt_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= hpbp_idle;
            is_wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            case (state_q)
                hpbp_idle: if (want_wr || want_rd) begin
                    state_q <= hpbp_wait;
                    is_wr_q <= want_wr;
                    cnt_q <= 2'(`HPBP_ACCESS_CYC - 1);
                end
                hpbp_wait: if (cnt_q == 2'h0) begin
                    state_q <= hpbp_done;
                end else begin
                    cnt_q <= cnt_q - 2'h1;
                end
                hpbp_done: if (!(want_wr || want_rd)) begin
                    state_q <= hpbp_idle; // Host ended cycle
                end
                default: state_q <= hpbp_idle;
            endcase
        end
    end

    // -----------------------------------------------
    // Core side access
    // -----------------------------------------------
    // Word address and write data, taken as the access opens
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_addr <= '0;
            core_wdata <= '0;
        end else if (state_q == hpbp_idle && (want_wr || want_rd)) begin
            core_addr <= addr_s2_q;
            if (want_wr) begin
                core_wdata <= data_s2_q;
            end
        end
    end

    // One-cycle core strobes; write data lands with the write strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_wr <= 1'b0;
            core_rd <= 1'b0;
        end else begin
            core_wr <= (state_q == hpbp_idle) && want_wr;
            core_rd <= (state_q == hpbp_idle) && want_rd;
        end
    end

    // -----------------------------------------------
    // Bus drive and ready
    // -----------------------------------------------
    hpbp_data_t rdata_q;
    logic drive_q;
    logic rdy_q;
    // Read word held from the core's answer
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else if (core_rd) begin
            rdata_q <= core_rdata;
        end
    end

    // Data bus driven from the second wait cycle of a read
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            drive_q <= 1'b0;
        end else begin
            drive_q <= (state_q != hpbp_idle) && !is_wr_q && sel;
        end
    end

    // Ready once the wait count ends; held while the host holds its strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= (state_q == hpbp_wait && cnt_q == 2'h0) || (state_q == hpbp_done && (want_wr || want_rd));
        end
    end
    // Enables gated by select, so both float as soon as it drops
    assign bus.host_data_bus_d_o = rdata_q;
    assign bus.host_data_bus_d_oe_n = !(drive_q && sel);
    assign bus.host_ready_out_o = rdy_q;
    assign bus.host_ready_out_oe_n = !(sel && state_q != hpbp_idle);

    // -----------------------------------------------
    // Interrupt outputs
    // -----------------------------------------------
    logic irq1_q;
    logic irq2_q;
    // Registered copies of the event levels
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq1_q <= 1'b0;
            irq2_q <= 1'b0;
        end else begin
            irq1_q <= main_event;
            irq2_q <= timer2_expired;
        end
    end
    assign bus.irq_main_out = irq1_q;
    assign bus.irq_timer_out = irq2_q;
endmodule : hpbp_device

// ==== logic/hpbp_host.sv ====
// Host (bus master) end of the host processor bus port.
// Assumes one user request at a time; ready is sampled through two flops.
`timescale 1ns/10ps
`include "hpbp_consts.svh"

module hpbp_host
    import hpbp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Bus mode
    input wire hpbp_mode_t bus_mode,
    // Port side
    hpbp_if.host bus,
    // User request
    input wire logic req_valid,
    input wire logic req_write,
    input wire hpbp_addr_t req_addr,
    input wire hpbp_data_t req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output hpbp_data_t rsp_rdata,
    // Interrupts seen
    output logic irq_main,
    output logic irq_timer
);
    typedef enum logic [1:0] {hh_idle, hh_run, hh_end} hh_state_t;

    // -----------------------------------------------
    // Input synchronisers
    // -----------------------------------------------
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    hpbp_data_t dat_s1_q;
    hpbp_data_t dat_s2_q;
    // Ready, interrupts and read data all pass two flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            dat_s1_q <= '0;
            dat_s2_q <= '0;
        end else begin
            s1_q <= {bus.host_ready_out_i, bus.irq_main_out, bus.irq_timer_out};
            s2_q <= s1_q;
            dat_s1_q <= bus.host_data_bus_i;
            dat_s2_q <= dat_s1_q;
        end
    end
    assign irq_main = s2_q[1];
    assign irq_timer = s2_q[0];

    // -----------------------------------------------
    // Cycle sequencer
    // -----------------------------------------------
    hh_state_t state_q;
    logic wr_q;
    hpbp_addr_t addr_q;
    hpbp_data_t wdata_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= hh_idle;
            wr_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= 1'b0;
            case (state_q)
                hh_idle: if (req_valid) begin
                    state_q <= hh_run;
                    wr_q <= req_write;
                    addr_q <= req_addr;
                    wdata_q <= req_wdata;
                end
                hh_run: if (s2_q[2]) begin
                    state_q <= hh_end;
                    rsp_valid <= !wr_q;
                    rsp_rdata <= dat_s2_q;
                end
                hh_end: if (!s2_q[2]) begin
                    state_q <= hh_idle;
                end
                default: state_q <= hh_idle;
            endcase
        end
    end
    assign req_ready = (state_q == hh_idle);

    // Pin drive per bus mode
    logic act;
    assign act = (state_q == hh_run);
    assign bus.host_select_n = !act;
    assign bus.host_address_bus = addr_q;
    assign bus.host_write_strobe = (bus_mode == hpbp_mode_strobe) ? (act && wr_q) : !wr_q;
    assign bus.host_read_strobe = act && ((bus_mode == hpbp_mode_tstart) || !wr_q);
    assign bus.host_data_bus_h_o = wdata_q;
    assign bus.host_data_bus_h_oe_n = !(act && wr_q);
endmodule : hpbp_host

// ==== testbench/hpbp_asserts.sv ====
// Checker for the host port wires and interrupt outputs.
// Assumes the bench instantiates it beside the joining interface.
`timescale 1ns/10ps

module hpbp_asserts
    import hpbp_pkg::*;
(
    // Clock, reset, mode
    input wire logic core_clk,
    input wire logic reset_n,
    input wire hpbp_mode_t bus_mode,
    // Port wires
    input wire logic host_select_n,
    input wire logic host_write_strobe,
    input wire logic host_read_strobe,
    input wire logic host_data_bus_h_oe_n,
    input wire logic host_data_bus_d_oe_n,
    input wire logic host_ready_out_o,
    input wire logic host_ready_out_oe_n,
    // Events and interrupts
    input wire logic main_event,
    input wire logic timer2_expired,
    input wire logic irq_main_out,
    input wire logic irq_timer_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // ------------------------------
    // Bus wire relations
    // ------------------------------
    one_driver_a: assert property (host_data_bus_h_oe_n || host_data_bus_d_oe_n)
        else $error("both ends drive data");
    idle_float_a: assert property (host_select_n [*8] |-> host_data_bus_d_oe_n && host_ready_out_oe_n)
        else $error("device drives while idle");
    ready_sel_a: assert property ($rose(host_ready_out_o && !host_ready_out_oe_n) |-> !host_select_n)
        else $error("ready without select");
    ready_time_a: assert property ($fell(host_select_n) |-> ##[2:12] host_ready_out_o && !host_ready_out_oe_n)
        else $error("ready late");
    sel_strobe_a: assert property (bus_mode == hpbp_mode_strobe && (host_write_strobe || host_read_strobe)
        |-> !host_select_n)
        else $error("strobe without select");
    strobe_excl_a: assert property (bus_mode == hpbp_mode_strobe |-> !(host_write_strobe && host_read_strobe))
        else $error("both strobes high");
    start_sel_a: assert property (bus_mode == hpbp_mode_tstart && host_read_strobe |-> !host_select_n)
        else $error("start without select");
    // ------------------------------
    // Interrupt outputs
    // ------------------------------
    irq_main_a: assert property (irq_main_out == $past(main_event))
        else $error("main interrupt wrong");
    irq_timer_a: assert property (irq_timer_out == $past(timer2_expired))
        else $error("timer interrupt wrong");
endmodule : hpbp_asserts

// ==== testbench/testbench.sv ====
// Bench joining both port ends with random and corner transfers.
// Assumes the logic files are compiled first; one 40 MHz clock.
`timescale 1ns/10ps

module testbench;
    import hpbp_pkg::*;
    logic core_clk, reset_n, req_valid, req_write, req_ready, rsp_valid, irq_main, irq_timer;
    logic core_wr, core_rd, main_event, timer2_expired;
    hpbp_mode_t bus_mode;
    hpbp_addr_t req_addr, core_addr, exp_addr;
    hpbp_data_t req_wdata, rsp_rdata, core_wdata, core_rdata, exp_wdata;
    int num_errors = 0;
    int compares = 0;
    int seed = 1;
    int cycles = 0;
    int wr_count = 0;
    int nwr = 0;
    hpbp_if bus_if ();
    // Wire resolution: data pulled up, ready low when floating
    assign bus_if.host_data_bus_i = !bus_if.host_data_bus_d_oe_n ? bus_if.host_data_bus_d_o :
        !bus_if.host_data_bus_h_oe_n ? bus_if.host_data_bus_h_o : 16'hffff;
    assign bus_if.host_ready_out_i = !bus_if.host_ready_out_oe_n && bus_if.host_ready_out_o;
    hpbp_device u_hpbp_device (.core_clk(core_clk), .reset_n(reset_n), .bus_mode(bus_mode), .bus(bus_if.device),
        .core_addr(core_addr), .core_wdata(core_wdata), .core_wr(core_wr), .core_rd(core_rd),
        .core_rdata(core_rdata), .main_event(main_event), .timer2_expired(timer2_expired));
    hpbp_host u_hpbp_host (.core_clk(core_clk), .reset_n(reset_n), .bus_mode(bus_mode), .bus(bus_if.host),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .irq_main(irq_main),
        .irq_timer(irq_timer));
    hpbp_asserts u_hpbp_asserts (.core_clk(core_clk), .reset_n(reset_n), .bus_mode(bus_mode),
        .host_select_n(bus_if.host_select_n), .host_write_strobe(bus_if.host_write_strobe),
        .host_read_strobe(bus_if.host_read_strobe), .host_data_bus_h_oe_n(bus_if.host_data_bus_h_oe_n),
        .host_data_bus_d_oe_n(bus_if.host_data_bus_d_oe_n), .host_ready_out_o(bus_if.host_ready_out_o),
        .host_ready_out_oe_n(bus_if.host_ready_out_oe_n), .main_event(main_event),
        .timer2_expired(timer2_expired), .irq_main_out(bus_if.irq_main_out), .irq_timer_out(bus_if.irq_timer_out));
    // ------------------------------
    // Helpers
    // ------------------------------
    // Read value the core side returns for an address
    function automatic hpbp_data_t rd_val(input hpbp_addr_t a);
        return a[15:0] ^ {14'h0000, a[17:16]} ^ 16'h5a3c;
    endfunction : rd_val
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    // One user transfer, followed on the wires
    task automatic xfer(input logic wr, input hpbp_addr_t a, input hpbp_data_t d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 60) begin
            @(negedge core_clk);
            n++;
        end
        exp_addr = a;
        exp_wdata = d;
        nwr += wr;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        @(negedge core_clk);
        req_valid = 1'b0;
        while (bus_if.host_select_n !== 1'b0 && n < 60) begin
            @(negedge core_clk);
            n++;
        end
        check(bus_if.host_address_bus, a);
        while (bus_if.host_ready_out_i !== 1'b1 && n < 60) begin
            @(negedge core_clk);
            n++;
        end
        check(bus_if.host_data_bus_i, wr ? d : rd_val(a));
        while (!wr && rsp_valid !== 1'b1 && n < 60) begin
            @(negedge core_clk);
            n++;
        end
        if (!wr) check(rsp_rdata, rd_val(a));
        check(n < 60, 1'b1);
    endtask : xfer
    // ------------------------------
    // Clock, core side, timeout
    // ------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Core register file answers reads
    always @(negedge core_clk) core_rdata <= rd_val(core_addr);
    // Core write strobe checked against the request
    always @(posedge core_clk) begin
        if (core_wr === 1'b1) begin
            check(core_addr, exp_addr);
            check(core_wdata, exp_wdata);
            wr_count++;
        end
        if (core_rd === 1'b1) begin
            check(core_addr, exp_addr);
        end
    end
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    // ------------------------------
    // Main sequence, both bus modes
    // ------------------------------
    initial begin
        {req_valid, req_write, req_addr, req_wdata, main_event, timer2_expired} = '0;
        for (int m = 0; m < 2; m++) begin
            reset_n = 1'b0;
            bus_mode = hpbp_mode_t'(m);
            repeat (2) @(negedge core_clk);
            reset_n = 1'b1;
            repeat (4) @(negedge core_clk);
            check(bus_if.host_data_bus_i, 16'hffff);
            check(bus_if.host_ready_out_i, 1'b0);
            xfer(1'b1, 18'h3ffff, 16'h8000);
            xfer(1'b0, 18'h3ffff, 16'h0000);
            xfer(1'b1, 18'h00000, 16'h0001);
            xfer(1'b0, 18'h00000, 16'h0000);
            for (int i = 0; i < 30; i++) xfer(1'($random(seed)), 18'($random(seed)), 16'($random(seed)));
            check(wr_count, nwr);
            main_event = 1'b1;
            repeat (4) @(negedge core_clk);
            check({irq_main, irq_timer, bus_if.irq_main_out}, 3'h5);
            main_event = 1'b0;
            timer2_expired = 1'b1;
            repeat (4) @(negedge core_clk);
            check({irq_main, irq_timer, bus_if.irq_timer_out}, 3'h3);
            timer2_expired = 1'b0;
            repeat (8) @(negedge core_clk);
            check(bus_if.host_data_bus_i, 16'hffff);
            $display("mode %0d done", m);
        end
        end_of_test();
    end
endmodule : testbench
